// [hw/srg_pkg.sv]
package srg_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   // Register offsets
   localparam logic [7:0] OFF_RESULT = 8'h90;
   localparam logic [7:0] OFF_SEED0 = 8'h91;
   localparam logic [7:0] OFF_SEED1 = 8'h92;
   localparam logic [7:0] OFF_SEED2 = 8'h93;
   localparam logic [7:0] OFF_SEED3 = 8'h94;
   localparam logic [7:0] OFF_CTRL = 8'h95;
   // Control field and reset
   localparam int unsigned CTRL_OSC_EN_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Seed shift register feedback taps (x^32+x^22+x^2+x+1)
   localparam logic [31:0] LFSR_TAPS = 32'h80200003;
   // Private oscillator divide: one oscillator step every OSC_DIV+1 system clocks
   localparam logic [3:0] OSC_DIV = 4'h3;
   // Oscillator steps run after start-up before the generator halts
   localparam logic [7:0] STARTUP_STEPS = 8'h40;
   typedef enum logic [1:0] {SRG_WARMUP, SRG_IDLE, SRG_RUN} srg_state_t;
endpackage

// [hw/srg_step_if.sv]
`timescale 1ns/1ps
interface srg_step_if;
   logic enable;
   logic step;
   modport osc(input enable, output step);
   modport core(output enable, input step);
endinterface

// [hw/srg_osc.sv]
`timescale 1ns/1ps
// Model of the private oscillator: a divider that only runs while enabled
module srg_osc
   import srg_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   srg_step_if.osc link
);
   logic [3:0] div_cnt;
   wire div_wrap = (div_cnt == OSC_DIV);
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !link.enable || div_wrap) begin
         div_cnt <= 4'h0;
      end else begin
         div_cnt <= div_cnt + 4'h1;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         link.step <= 1'b0;
      end else begin
         link.step <= link.enable && div_wrap;
      end
   end
endmodule // srg_osc

// [hw/srg_post.sv]
`timescale 1ns/1ps
// Post-processing: folds shift register into an accumulator every clock while run_i is high
module srg_post
   import srg_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic run_i,
   input wire logic [31:0] state_i,
   output logic [7:0] value_o
);
   logic run_q;
   wire [7:0] fold = state_i[31:24] ^ state_i[23:16] ^ state_i[15:8] ^ state_i[7:0];
   wire start = run_i && !run_q;
   // Reload from the seed on each start: with no reset, a pure accumulator
   // would never leave its unknown power-up value
   wire [7:0] next_value = start ? fold : ({value_o[6:0], value_o[7]} ^ fold);
   always_ff @(posedge sys_clk_i) begin
      run_q <= run_i;
   end
   // No reset: the result is undefined until the first start loads it from the seed
   always_ff @(posedge sys_clk_i) begin
      if (run_i) begin
         value_o <= next_value;
      end
   end
endmodule // srg_post

// [hw/srg_top.sv]
// Strobed register access was decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Setting control bit 0 starts the oscillator and random generation.
// - With the enable clear and warm-up done, oscillator, shift register and post-processing halt.
// - On stop, seed and result registers keep their last-step values.
// - Seed is 32 bits over four byte registers, MSB at highest address.
// - Running state evolves from the seed and earlier iterations.
// - Seed register contents change as the shift register advances.
// - Read-only result byte updates every system clock while running.
// - After start-up the generator runs some steps to vary its state.
// - Control bits 7..1 read zero; control resets to zero, generator enters warm-up.
module srg_top
   import srg_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic running_o
);
   srg_step_if step_link();
   srg_state_t state;
   srg_state_t next_state;
   logic osc_enable;
   logic [31:0] seed;
   logic [7:0] warm_cnt;
   logic [7:0] result;

   // Decoding
   wire wr_ctrl = wr_i && (addr_i == OFF_CTRL);
   wire [3:0] wr_seed;
   assign wr_seed[0] = wr_i && (addr_i == OFF_SEED0);
   assign wr_seed[1] = wr_i && (addr_i == OFF_SEED1);
   assign wr_seed[2] = wr_i && (addr_i == OFF_SEED2);
   assign wr_seed[3] = wr_i && (addr_i == OFF_SEED3);
   wire run = (state != SRG_IDLE);
   wire seed_write_ok = (state == SRG_IDLE) && !osc_enable;

   // Shift register advance: Galois form
   wire [31:0] lfsr_next = seed[0] ? ((seed >> 1) ^ LFSR_TAPS) : (seed >> 1);

   always_comb begin
      next_state = state;
      case (state)
         SRG_WARMUP: begin
            if (warm_cnt == STARTUP_STEPS) begin
               next_state = osc_enable ? SRG_RUN : SRG_IDLE;
            end
         end
         SRG_IDLE: begin
            if (osc_enable) begin
               next_state = SRG_RUN;
            end
         end
         SRG_RUN: begin
            if (!osc_enable) begin
               next_state = SRG_IDLE;
            end
         end
         default: next_state = SRG_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state <= SRG_WARMUP;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         warm_cnt <= 8'h00;
      end else if (state == SRG_WARMUP && step_link.step) begin
         warm_cnt <= warm_cnt + 8'h01;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         osc_enable <= CTRL_RESET[CTRL_OSC_EN_BIT];
      end else if (wr_ctrl) begin
         osc_enable <= wdata_i[CTRL_OSC_EN_BIT];
      end
   end

   assign step_link.enable = run;
   srg_osc u_osc (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .link(step_link)
   );

   // Seed holds no reset so power-up noise plus warm-up steps give a varied state
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_seed
         always_ff @(posedge sys_clk_i) begin
            if (run && step_link.step) begin
               seed[b*8 +: 8] <= lfsr_next[b*8 +: 8];
            end else if (wr_seed[b] && seed_write_ok) begin
               seed[b*8 +: 8] <= wdata_i;
            end
         end
      end
   endgenerate

   // Result keeps its last value once halted
   srg_post u_post (
      .sys_clk_i(sys_clk_i),
      .run_i(run),
      .state_i(seed),
      .value_o(result)
   );

   // Read mux
   logic [7:0] rd_mux;
   always_comb begin
      case (addr_i)
         OFF_RESULT: rd_mux = result;
         OFF_SEED0: rd_mux = seed[7:0];
         OFF_SEED1: rd_mux = seed[15:8];
         OFF_SEED2: rd_mux = seed[23:16];
         OFF_SEED3: rd_mux = seed[31:24];
         OFF_CTRL: rd_mux = {7'h00, osc_enable};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
         running_o <= 1'b0;
      end else begin
         rdata_o <= rd_i ? rd_mux : 8'h00;
         running_o <= (next_state != SRG_IDLE);
      end
   end
endmodule // srg_top

// [verif/srg_top_sva.sv]
`timescale 1ns/1ps
module srg_sva
   import srg_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic running_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   wire go = wr_i && addr_i == OFF_CTRL && wdata_i[CTRL_OSC_EN_BIT];
   wire rd_ctrl = rd_i && addr_i == OFF_CTRL;
   wire rr = rd_i && addr_i == OFF_RESULT && !running_o;
   ctrl_rsvd_a: assert property (rd_ctrl |=> rdata_o[7:1] == 7'h00)
      else $error("ctrl bits set");
   // The enable lands one edge after the write and the state one edge later
   run_start_a: assert property (go |-> ##2 running_o)
      else $error("no start");
   stay_stopped_a: assert property (!$past(rst_i) && !$past(go) && !running_o && !go |=> !running_o)
      else $error("self start");
   stop_ctrl_a: assert property (rd_ctrl && !running_o && !$past(go) |=> rdata_o == 8'h00)
      else $error("ctrl not clear");
   warm_up_a: assert property ($fell(rst_i) |=> running_o [*8])
      else $error("no warm-up");
   unmapped_read_a: assert property (rd_i && !(addr_i inside {[OFF_RESULT:OFF_CTRL]}) |=> rdata_o == 8'h00)
      else $error("unmapped data");
   idle_data_a: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("stray data");
   result_hold_a: assert property (rr ##2 rr |=> rdata_o == $past(rdata_o, 2))
      else $error("result moved");
endmodule // srg_sva
bind srg_top srg_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .running_o(running_o));

// [verif/srg_tb_top.sv]
`timescale 1ns/1ps
module srg_tb_top;
   import srg_pkg::*;
   logic sys_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, running_o, same;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, x, v;
   logic [31:0] s, t;
   int errors = 0, comparisons = 0;
   srg_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .running_o(running_o));
   always #20 sys_clk_i = ~sys_clk_i;
   task automatic chk(string n, logic [31:0] g, logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   // One bus cycle: w=1 writes, w=0 reads into x
   task automatic acc(logic w, logic [7:0] a, logic [7:0] v);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= w;
      rd_i <= !w;
      @(posedge sys_clk_i);
      {wr_i, rd_i} <= 2'h0;
      #1 x = rdata_o;
   endtask
   task automatic rds;
      for (int i = 0; i < 4; i++) begin
         acc(0, 8'(OFF_SEED0 + i), 8'h00);
         s[8*i+:8] = x;
      end
   endtask
   task automatic wrs(logic [31:0] v);
      for (int i = 0; i < 4; i++) acc(1, 8'(OFF_SEED0 + i), v[8*i+:8]);
   endtask
   // Holds reset for 20 edges, then waits out the start-up warm-up
   task automatic restart;
      rst_i <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1 chk("warm", running_o, 32'h1);
      for (int i = 0; i < 2000 && running_o !== 1'b0; i++) @(posedge sys_clk_i);
      #1 chk("warm_end", running_o, 32'h0);
      acc(0, OFF_CTRL, 8'h00);
      chk("ctrl", x, 32'h0);
   endtask
   task automatic complete_run;
      if (errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      errors++;
      complete_run;
   end
   initial begin
      restart;
      wrs(32'h44332211);
      rds;
      chk("seed", s, 32'h44332211);
      acc(1, OFF_CTRL, 8'hFF);
      // The state follows the enable one edge later
      @(posedge sys_clk_i) #1 chk("run", running_o, 32'h1);
      acc(0, OFF_CTRL, 8'h00);
      chk("ctrl_rsvd", x, 32'h1);
      acc(0, OFF_RESULT, 8'h00);
      v = x;
      same = 1'b1;
      for (int i = 0; i < 8; i++) begin
         acc(0, OFF_RESULT, 8'h00);
         if (x !== v) same = 1'b0;
      end
      chk("changing", same, 32'h0);
      repeat (40) @(posedge sys_clk_i);
      acc(1, OFF_CTRL, 8'h00);
      rds;
      chk("moved", s == 32'h44332211, 32'h0);
      t = s;
      rds;
      chk("seed_hold", s, t);
      acc(0, OFF_RESULT, 8'h00);
      s[7:0] = x;
      chk("res_known", 32'($isunknown(x)), 32'h0);
      acc(0, OFF_RESULT, 8'h00);
      chk("hold", x, s[7:0]);
      acc(1, OFF_RESULT, ~x);
      acc(0, OFF_RESULT, 8'h00);
      chk("ro", x, s[7:0]);
      // A zero seed never moves, so an accepted running write would show
      wrs(32'h0);
      acc(1, OFF_CTRL, 8'h01);
      acc(1, OFF_SEED0, 8'hFF);
      acc(1, OFF_CTRL, 8'h00);
      rds;
      chk("ignored", s, 32'h0);
      acc(0, 8'h80, 8'h00);
      chk("unmapped", x, 32'h0);
      // Reset while running must clear the enable and warm up again
      acc(1, OFF_CTRL, 8'h01);
      @(posedge sys_clk_i);
      restart;
      complete_run;
   end
endmodule // srg_tb_top
